/* File: src/ext_alu_pkg.sv */
package ext_alu_pkg;

	// Datapath and bus widths.
	localparam int unsigned DATA_W = 20;
	localparam int unsigned ADR_W = 8;

	// Register byte offsets on the bus.
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_SRC = 8'h04;
	localparam logic [7:0] ADR_DST = 8'h08;
	localparam logic [7:0] ADR_FLAGS = 8'h0c;
	localparam logic [7:0] ADR_RESULT = 8'h10;
	localparam logic [7:0] ADR_STATUS = 8'h14;
	localparam logic [7:0] ADR_SP = 8'h18;
	localparam logic [7:0] ADR_PC = 8'h1c;
	localparam logic [7:0] ADR_ADDR_LO = 8'h20;
	localparam logic [7:0] ADR_ADDR_HI = 8'h24;
	localparam logic [7:0] ADR_OPADDR = 8'h28;
	localparam logic [1:0] ADR_REGS_TOP = 2'b01;

	// Control word fields.
	localparam int unsigned CTL_OP_LSB = 0;
	localparam int unsigned CTL_BW = 8;
	localparam int unsigned CTL_AL = 9;
	localparam int unsigned CTL_MEM = 10;
	localparam int unsigned CTL_CNT_LSB = 12;
	localparam int unsigned CTL_REG_LSB = 16;
	localparam int unsigned CTL_GO = 31;

	// Flag positions inside the four-bit flag register.
	localparam int unsigned FLG_C = 0;
	localparam int unsigned FLG_Z = 1;
	localparam int unsigned FLG_N = 2;
	localparam int unsigned FLG_V = 3;

	// Status bits.
	localparam int unsigned STS_BUSY = 0;
	localparam int unsigned STS_LENERR = 1;

	// Width masks and sign-bit masks.
	localparam logic [19:0] MASK_8 = 20'h0_00ff;
	localparam logic [19:0] MASK_16 = 20'h0_ffff;
	localparam logic [19:0] MASK_20 = 20'hf_ffff;
	localparam logic [19:0] SIGN_8 = 20'h0_0080;
	localparam logic [19:0] SIGN_16 = 20'h0_8000;
	localparam logic [19:0] SIGN_20 = 20'h8_0000;
	localparam logic [19:0] ONE_20 = 20'h0_0001;

	// Reset values.
	localparam logic [19:0] SP_RESET = 20'h0_0000;
	localparam logic [19:0] PC_RESET = 20'h0_0000;

	// Largest count field accepted by the multi-bit rotates (n-1).
	localparam logic [3:0] ROT_CNT_MAX = 4'h3;
	localparam logic [4:0] BCD_LIMIT = 5'h09;
	localparam logic [4:0] BCD_ADJ = 5'h06;

	typedef enum logic [1:0] {
		W_NONE = 2'b00,
		W_8 = 2'b01,
		W_16 = 2'b10,
		W_20 = 2'b11
	} width_e;

	typedef enum logic [4:0] {
		OP_MOVE = 5'b00000,
		OP_ADD = 5'b00001,
		OP_ADDC = 5'b00010,
		OP_SUB = 5'b00011,
		OP_SUBC = 5'b00100,
		OP_CMP = 5'b00101,
		OP_DADD = 5'b00110,
		OP_BIT = 5'b00111,
		OP_BIC = 5'b01000,
		OP_BIS = 5'b01001,
		OP_XOR = 5'b01010,
		OP_AND = 5'b01011,
		OP_FAR_CALL = 5'b01100,
		OP_MPUSH = 5'b01101,
		OP_MPOP = 5'b01110,
		OP_PUSH = 5'b01111,
		OP_MULTI_ROTATE_RIGHT_CARRY = 5'b10000,
		OP_MULTI_ROTATE_RIGHT_UNSIGNED = 5'b10001,
		OP_MULTI_ROTATE_RIGHT_ARITH = 5'b10010,
		OP_MULTI_SHIFT_LEFT_ARITH = 5'b10011,
		OP_EXT_ROTATE_RIGHT_CARRY = 5'b10100,
		OP_EXT_ROTATE_RIGHT_UNSIGNED = 5'b10101,
		OP_EXT_ROTATE_RIGHT_ARITH = 5'b10110,
		OP_SWPB = 5'b10111,
		OP_SXT = 5'b11000
	} op_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EXEC = 2'b01,
		ST_MULTI = 2'b10
	} state_e;

endpackage : ext_alu_pkg

/* File: src/extended_instruction_alu.sv */
// Operation
// - Length from length bit and byte/word bit; 0/0 is reserved and refused, except for multi, far call, byte swap and sign extend.
// - Byte swap and sign extend: 0/0 is 20-bit, 1/0 is 16-bit, others refused.
// - All twelve double-operand operations exist at 8, 16 and 20 bits.
// - Add and add-with-carry write the sum and update all four flags.
// - Subtract writes dst + ~src + 1; compare sets flags only.
// - Subtract-with-carry writes dst + ~src + carry and updates all flags.
// - Decimal add writes BCD sum of source, destination and carry; flags updated.
// - AND writes, bit-test only computes; V cleared, N and Z set, C = not Z.
// - Exclusive-OR writes result, updates V, N, Z and sets C = not Z.
// - Bit-clear and bit-set write their result and leave flags alone.
// - A 20-bit operand address held in memory is taken as two words.
// - Far call branches to a 20-bit target, flags untouched.
// - Multi push stores 1 to 16 consecutive registers at 16 or 20 bits.
// - Multi pop restores 1 to 16 consecutive registers at 16 or 20 bits.
// - Push places an 8, 16 or 20-bit source on the stack, flags untouched.
// - Multi right rotates shift 1 to 4 bits, clear V, update N, Z, C.
// - Multi arithmetic left shift by 1 to 4 bits updates all four flags.
// - Single right rotates shift once, clear V, update N, Z, C.
// - Byte swap exchanges low and high bytes, flags untouched.
// - Sign extend copies bit 7 upward, clears V, sets N, Z, C = not Z.
`timescale 1ns/1ps
module extended_instruction_alu
	import ext_alu_pkg::*;
#(
	parameter int unsigned STACK_DEPTH = 32
)
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	// Wishbone slave
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [ADR_W-1:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	// Status
	output logic busy_out
);

	localparam int unsigned SP_IDX_W = $clog2(STACK_DEPTH);

	state_e state_r;
	op_e op_r;
	width_e wid_r;
	logic mem_r;
	logic [3:0] cnt_r;
	logic [3:0] idx_r;
	logic [19:0] src_r;
	logic [19:0] dst_r;
	logic [19:0] result_r;
	logic [3:0] flags_r;
	logic [19:0] sp_r;
	logic [19:0] pc_r;
	logic [15:0] addr_lo_r;
	logic [15:0] addr_hi_r;
	logic len_err_r;
	logic busy_r;
	logic ack_r;
	logic [31:0] rdata_r;
	logic [19:0] regs_r [16];
	logic [19:0] stack_r [STACK_DEPTH];

	logic bus_req;
	logic bus_wr;
	logic bus_rd;
	logic go;
	width_e go_wid;
	logic [19:0] res_nxt;
	logic [3:0] flags_nxt;
	logic wr_dst_nxt;
	logic [19:0] mask;
	logic [19:0] target;
	logic [19:0] sp_dec;
	logic [SP_IDX_W-1:0] sp_idx;
	logic [SP_IDX_W-1:0] sp_dec_idx;
	logic [31:0] sel_bits;

	function automatic logic [19:0] mask_of(input width_e w);
		case (w)
			W_8: mask_of = MASK_8;
			W_16: mask_of = MASK_16;
			default: mask_of = MASK_20;
		endcase
	endfunction : mask_of

	function automatic logic [19:0] sign_of(input width_e w);
		case (w)
			W_8: sign_of = SIGN_8;
			W_16: sign_of = SIGN_16;
			default: sign_of = SIGN_20;
		endcase
	endfunction : sign_of

	function automatic logic msb(input logic [19:0] x, input width_e w);
		msb = |(x & sign_of(w));
	endfunction : msb

	function automatic logic cout(input logic [20:0] s, input width_e w);
		case (w)
			W_8: cout = s[8];
			W_16: cout = s[16];
			default: cout = s[20];
		endcase
	endfunction : cout

	function automatic width_e decode_width(input op_e op, input logic al, input logic bw,
		input logic [3:0] cnt);
		case (op)
			OP_SWPB, OP_SXT:
			begin
				if (bw)
				begin
					decode_width = W_NONE;
				end
				else
				begin
					decode_width = al ? W_16 : W_20;
				end
			end
			OP_MPUSH, OP_MPOP:
			begin
				decode_width = al ? W_16 : W_20;
			end
			OP_MULTI_ROTATE_RIGHT_CARRY, OP_MULTI_ROTATE_RIGHT_UNSIGNED, OP_MULTI_ROTATE_RIGHT_ARITH, OP_MULTI_SHIFT_LEFT_ARITH:
			begin
				if (cnt > ROT_CNT_MAX)
				begin
					decode_width = W_NONE;
				end
				else
				begin
					decode_width = al ? W_16 : W_20;
				end
			end
			OP_FAR_CALL:
			begin
				decode_width = W_20;
			end
			default:
			begin
				case ({al, bw})
					2'b01: decode_width = W_20;
					2'b10: decode_width = W_16;
					2'b11: decode_width = W_8;
					default: decode_width = W_NONE;
				endcase
			end
		endcase
	endfunction : decode_width

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode.

	assign bus_req = wb_cyc_in && wb_stb_in && !ack_r;
	assign bus_wr = bus_req && wb_we_in;
	assign bus_rd = bus_req && !wb_we_in;
	assign go = bus_wr && (wb_adr_in == ADR_CTRL) && wb_sel_in[3] && wb_dat_in[CTL_GO]
		&& (state_r == ST_IDLE);
	assign go_wid = decode_width(op_e'(wb_dat_in[CTL_OP_LSB +: 5]), wb_dat_in[CTL_AL],
		wb_dat_in[CTL_BW], wb_dat_in[CTL_CNT_LSB +: 4]);
	assign mask = mask_of(wid_r);
	// A memory-held operand address arrives as two separate words.
	assign target = mem_r ? {addr_hi_r[3:0], addr_lo_r} : dst_r;
	assign sp_dec = sp_r - ONE_20;
	assign sp_idx = sp_r[SP_IDX_W-1:0];
	assign sp_dec_idx = sp_dec[SP_IDX_W-1:0];
	// Byte enables spread to bit masks, so every register write except the control word keeps unselected bytes.
	assign sel_bits = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
	assign wb_ack_out = ack_r;
	assign wb_dat_out = rdata_r;
	assign busy_out = busy_r;

	////////////////////////////////////////////////////////////////////////////////
	// Datapath.

	always_comb
	begin
		logic [19:0] s;
		logic [19:0] d;
		logic [19:0] b;
		logic [19:0] r;
		logic [20:0] sum;
		logic [4:0] dig;
		logic c;
		logic ci;
		logic fill;
		logic arith;
		s = src_r & mask;
		d = dst_r & mask;
		b = s;
		r = d;
		sum = 21'h0_0000;
		dig = 5'h00;
		c = flags_r[FLG_C];
		ci = 1'b0;
		fill = 1'b0;
		arith = 1'b0;
		res_nxt = d;
		flags_nxt = flags_r;
		wr_dst_nxt = 1'b0;
		case (op_r)
			OP_MOVE:
			begin
				res_nxt = s;
				wr_dst_nxt = 1'b1;
			end
			OP_ADD, OP_ADDC:
			begin
				arith = 1'b1;
				ci = (op_r == OP_ADDC) && flags_r[FLG_C];
				wr_dst_nxt = 1'b1;
			end
			OP_SUB, OP_SUBC, OP_CMP:
			begin
				arith = 1'b1;
				b = ~s & mask;
				ci = (op_r == OP_SUBC) ? flags_r[FLG_C] : 1'b1;
				wr_dst_nxt = (op_r != OP_CMP);
			end
			OP_DADD:
			begin
				for (int k = 0; k < 5; k++)
				begin
					dig = {1'b0, d[4*k +: 4]} + {1'b0, s[4*k +: 4]} + {4'h0, c};
					if (dig > BCD_LIMIT)
					begin
						dig = dig + BCD_ADJ;
					end
					r[4*k +: 4] = dig[3:0];
					if ((mask & (20'h0_000f << (4*k))) != 20'h0_0000)
					begin
						c = dig[4] || (dig[3:0] < d[4*k +: 4] && dig[4]);
					end
				end
				res_nxt = r & mask;
				flags_nxt[FLG_C] = c;
				flags_nxt[FLG_N] = msb(res_nxt, wid_r);
				flags_nxt[FLG_Z] = (res_nxt == 20'h0_0000);
				flags_nxt[FLG_V] = (msb(d, wid_r) == msb(s, wid_r))
					&& (msb(res_nxt, wid_r) != msb(d, wid_r));
				wr_dst_nxt = 1'b1;
			end
			OP_BIT, OP_AND:
			begin
				res_nxt = s & d;
				flags_nxt[FLG_V] = 1'b0;
				flags_nxt[FLG_N] = msb(res_nxt, wid_r);
				flags_nxt[FLG_Z] = (res_nxt == 20'h0_0000);
				flags_nxt[FLG_C] = (res_nxt != 20'h0_0000);
				wr_dst_nxt = (op_r == OP_AND);
				if (op_r == OP_BIT)
				begin
					res_nxt = d;
				end
			end
			OP_XOR:
			begin
				res_nxt = s ^ d;
				flags_nxt[FLG_V] = msb(s, wid_r) && msb(d, wid_r);
				flags_nxt[FLG_N] = msb(res_nxt, wid_r);
				flags_nxt[FLG_Z] = (res_nxt == 20'h0_0000);
				flags_nxt[FLG_C] = (res_nxt != 20'h0_0000);
				wr_dst_nxt = 1'b1;
			end
			OP_BIC:
			begin
				res_nxt = ~s & d;
				wr_dst_nxt = 1'b1;
			end
			OP_BIS:
			begin
				res_nxt = s | d;
				wr_dst_nxt = 1'b1;
			end
			OP_MULTI_ROTATE_RIGHT_CARRY, OP_MULTI_ROTATE_RIGHT_UNSIGNED, OP_MULTI_ROTATE_RIGHT_ARITH, OP_EXT_ROTATE_RIGHT_CARRY, OP_EXT_ROTATE_RIGHT_UNSIGNED, OP_EXT_ROTATE_RIGHT_ARITH:
			begin
				// Single rotates reuse the multi path with a count of one.
				for (int k = 0; k < 4; k++)
				begin
					if (k == 0 || (k <= int'(cnt_r) && op_r inside {OP_MULTI_ROTATE_RIGHT_CARRY, OP_MULTI_ROTATE_RIGHT_UNSIGNED, OP_MULTI_ROTATE_RIGHT_ARITH}))
					begin
						case (op_r)
							OP_MULTI_ROTATE_RIGHT_CARRY, OP_EXT_ROTATE_RIGHT_CARRY: fill = c;
							OP_MULTI_ROTATE_RIGHT_ARITH, OP_EXT_ROTATE_RIGHT_ARITH: fill = msb(r, wid_r);
							default: fill = 1'b0;
						endcase
						c = r[0];
						r = (r >> 1) | (fill ? sign_of(wid_r) : 20'h0_0000);
					end
				end
				res_nxt = r;
				flags_nxt[FLG_V] = 1'b0;
				flags_nxt[FLG_N] = msb(r, wid_r);
				flags_nxt[FLG_Z] = (r == 20'h0_0000);
				flags_nxt[FLG_C] = c;
				wr_dst_nxt = 1'b1;
			end
			OP_MULTI_SHIFT_LEFT_ARITH:
			begin
				flags_nxt[FLG_V] = 1'b0;
				for (int k = 0; k < 4; k++)
				begin
					if (k <= int'(cnt_r))
					begin
						c = msb(r, wid_r);
						r = (r << 1) & mask;
						if (msb(r, wid_r) != c)
						begin
							flags_nxt[FLG_V] = 1'b1;
						end
					end
				end
				res_nxt = r;
				flags_nxt[FLG_N] = msb(r, wid_r);
				flags_nxt[FLG_Z] = (r == 20'h0_0000);
				flags_nxt[FLG_C] = c;
				wr_dst_nxt = 1'b1;
			end
			OP_SWPB:
			begin
				res_nxt = {d[19:16], d[7:0], d[15:8]} & mask;
				wr_dst_nxt = 1'b1;
			end
			OP_SXT:
			begin
				res_nxt = {{12{d[7]}}, d[7:0]} & mask;
				flags_nxt[FLG_V] = 1'b0;
				flags_nxt[FLG_N] = msb(res_nxt, wid_r);
				flags_nxt[FLG_Z] = (res_nxt == 20'h0_0000);
				flags_nxt[FLG_C] = (res_nxt != 20'h0_0000);
				wr_dst_nxt = 1'b1;
			end
			default:
			begin
				res_nxt = d;
			end
		endcase
		if (arith)
		begin
			sum = {1'b0, d} + {1'b0, b} + {20'h0_0000, ci};
			res_nxt = sum[19:0] & mask;
			flags_nxt[FLG_C] = cout(sum, wid_r);
			flags_nxt[FLG_N] = msb(res_nxt, wid_r);
			flags_nxt[FLG_Z] = (res_nxt == 20'h0_0000);
			flags_nxt[FLG_V] = (msb(d, wid_r) == msb(b, wid_r))
				&& (msb(res_nxt, wid_r) != msb(d, wid_r));
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer: one cycle for single operations, one stack word per cycle for multi.

	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			state_r <= ST_IDLE;
			op_r <= OP_MOVE;
			wid_r <= W_NONE;
			mem_r <= 1'b0;
			cnt_r <= 4'h0;
			idx_r <= 4'h0;
			busy_r <= 1'b0;
		end
		else
		begin
			case (state_r)
				ST_IDLE:
				begin
					if (go && go_wid != W_NONE)
					begin
						state_r <= ST_EXEC;
						busy_r <= 1'b1;
						op_r <= op_e'(wb_dat_in[CTL_OP_LSB +: 5]);
						wid_r <= go_wid;
						mem_r <= wb_dat_in[CTL_MEM];
						cnt_r <= wb_dat_in[CTL_CNT_LSB +: 4];
						idx_r <= wb_dat_in[CTL_REG_LSB +: 4];
					end
				end
				ST_EXEC:
				begin
					if (op_r == OP_MPUSH || op_r == OP_MPOP)
					begin
						state_r <= ST_MULTI;
						if (op_r == OP_MPOP)
						begin
							idx_r <= idx_r - cnt_r;
						end
					end
					else
					begin
						state_r <= ST_IDLE;
						busy_r <= 1'b0;
					end
				end
				ST_MULTI:
				begin
					idx_r <= (op_r == OP_MPUSH) ? idx_r - 4'h1 : idx_r + 4'h1;
					cnt_r <= cnt_r - 4'h1;
					if (cnt_r == 4'h0)
					begin
						state_r <= ST_IDLE;
						busy_r <= 1'b0;
					end
				end
				default:
				begin
					state_r <= ST_IDLE;
					busy_r <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Operand, flag and result registers.

	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			src_r <= 20'h0_0000;
			dst_r <= 20'h0_0000;
			result_r <= 20'h0_0000;
			flags_r <= 4'h0;
			addr_lo_r <= 16'h0000;
			addr_hi_r <= 16'h0000;
		end
		else if (state_r == ST_EXEC)
		begin
			if (!(op_r inside {OP_FAR_CALL, OP_PUSH, OP_MPUSH, OP_MPOP}))
			begin
				result_r <= res_nxt;
				flags_r <= flags_nxt;
				if (wr_dst_nxt)
				begin
					dst_r <= res_nxt;
				end
			end
		end
		else if (bus_wr && state_r == ST_IDLE)
		begin
			case (wb_adr_in)
				ADR_SRC: src_r <= (src_r & ~sel_bits[19:0])
					| (wb_dat_in[19:0] & sel_bits[19:0]);
				ADR_DST: dst_r <= (dst_r & ~sel_bits[19:0])
					| (wb_dat_in[19:0] & sel_bits[19:0]);
				ADR_FLAGS: flags_r <= (flags_r & ~sel_bits[3:0])
					| (wb_dat_in[3:0] & sel_bits[3:0]);
				ADR_ADDR_LO: addr_lo_r <= (addr_lo_r & ~sel_bits[15:0])
					| (wb_dat_in[15:0] & sel_bits[15:0]);
				ADR_ADDR_HI: addr_hi_r <= (addr_hi_r & ~sel_bits[15:0])
					| (wb_dat_in[15:0] & sel_bits[15:0]);
				default:
				begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register file, stack, stack pointer and program counter.

	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			sp_r <= SP_RESET;
			pc_r <= PC_RESET;
			for (int i = 0; i < 16; i++)
			begin
				regs_r[i] <= 20'h0_0000;
			end
			for (int i = 0; i < STACK_DEPTH; i++)
			begin
				stack_r[i] <= 20'h0_0000;
			end
		end
		else if (state_r == ST_EXEC && op_r == OP_FAR_CALL)
		begin
			stack_r[sp_dec_idx] <= pc_r;
			sp_r <= sp_dec;
			pc_r <= target;
		end
		else if (state_r == ST_EXEC && op_r == OP_PUSH)
		begin
			stack_r[sp_dec_idx] <= src_r & mask;
			sp_r <= sp_dec;
		end
		else if (state_r == ST_MULTI && op_r == OP_MPUSH)
		begin
			stack_r[sp_dec_idx] <= regs_r[idx_r] & mask;
			sp_r <= sp_dec;
		end
		else if (state_r == ST_MULTI && op_r == OP_MPOP)
		begin
			regs_r[idx_r] <= stack_r[sp_idx] & mask;
			sp_r <= sp_r + ONE_20;
		end
		else if (bus_wr && state_r == ST_IDLE)
		begin
			if (wb_adr_in == ADR_SP)
			begin
				sp_r <= (sp_r & ~sel_bits[19:0]) | (wb_dat_in[19:0] & sel_bits[19:0]);
			end
			if (wb_adr_in == ADR_PC)
			begin
				pc_r <= (pc_r & ~sel_bits[19:0]) | (wb_dat_in[19:0] & sel_bits[19:0]);
			end
			if (wb_adr_in[7:6] == ADR_REGS_TOP)
			begin
				regs_r[wb_adr_in[5:2]] <= (regs_r[wb_adr_in[5:2]] & ~sel_bits[19:0])
					| (wb_dat_in[19:0] & sel_bits[19:0]);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus answer and sticky length error. A new refusal wins over a clear.

	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			ack_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			len_err_r <= 1'b0;
		end
		else
		begin
			ack_r <= bus_req;
			if (go && go_wid == W_NONE)
			begin
				len_err_r <= 1'b1;
			end
			else if (bus_wr && wb_adr_in == ADR_STATUS && wb_sel_in[0] && wb_dat_in[STS_LENERR])
			begin
				len_err_r <= 1'b0;
			end
			if (bus_rd)
			begin
				rdata_r <= 32'h0000_0000;
				case (wb_adr_in)
					ADR_CTRL: rdata_r <= {10'h000, wid_r, idx_r, cnt_r, 1'b0, mem_r, 5'h00, op_r};
					ADR_SRC: rdata_r <= {12'h000, src_r};
					ADR_DST: rdata_r <= {12'h000, dst_r};
					ADR_FLAGS: rdata_r <= {28'h000_0000, flags_r};
					ADR_RESULT: rdata_r <= {12'h000, result_r};
					ADR_STATUS: rdata_r <= {30'h0000_0000, len_err_r, busy_r};
					ADR_SP: rdata_r <= {12'h000, sp_r};
					ADR_PC: rdata_r <= {12'h000, pc_r};
					ADR_ADDR_LO: rdata_r <= {16'h0000, addr_lo_r};
					ADR_ADDR_HI: rdata_r <= {16'h0000, addr_hi_r};
					ADR_OPADDR: rdata_r <= {12'h000, addr_hi_r[3:0], addr_lo_r};
					default:
					begin
						if (wb_adr_in[7:6] == ADR_REGS_TOP)
						begin
							rdata_r <= {12'h000, regs_r[wb_adr_in[5:2]]};
						end
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!resetn_in);

	AST_RESERVED_LEN: assert property (go && go_wid == W_NONE
		|=> state_r == ST_IDLE && len_err_r)
		else $error("reserved length was not refused");
	AST_MOVE_FLAGS: assert property (state_r == ST_EXEC && op_r == OP_MOVE
		|=> flags_r == $past(flags_r) && dst_r == ($past(src_r) & $past(mask)))
		else $error("move changed flags or wrong data");
	AST_CMP_NO_WRITE: assert property (state_r == ST_EXEC && op_r == OP_CMP
		|=> dst_r == $past(dst_r))
		else $error("compare wrote destination");
	AST_AND_CARRY: assert property (state_r == ST_EXEC && op_r inside {OP_AND, OP_BIT}
		|=> flags_r[FLG_C] == !flags_r[FLG_Z] && !flags_r[FLG_V])
		else $error("and flags wrong");
	AST_BIC_FLAGS: assert property (state_r == ST_EXEC && op_r inside {OP_BIC, OP_BIS}
		|=> $stable(flags_r))
		else $error("bit clear or set altered flags");
	AST_CALL: assert property (state_r == ST_EXEC && op_r == OP_FAR_CALL
		|=> pc_r == $past(target) && $stable(flags_r) && sp_r == $past(sp_dec))
		else $error("far call target or flags wrong");
	AST_MPUSH_STEP: assert property (state_r == ST_MULTI && op_r == OP_MPUSH
		|=> sp_r == $past(sp_dec))
		else $error("multi push did not step stack");
	AST_MULTI_LEN: assert property (state_r == ST_EXEC && op_r == OP_MPOP
		&& cnt_r == 4'h1
		|=> state_r == ST_MULTI ##1 state_r == ST_MULTI ##1 state_r == ST_IDLE)
		else $error("multi pop length wrong");
	AST_ROT_V: assert property (state_r == ST_EXEC
		&& op_r inside {OP_MULTI_ROTATE_RIGHT_CARRY, OP_MULTI_ROTATE_RIGHT_UNSIGNED, OP_MULTI_ROTATE_RIGHT_ARITH, OP_EXT_ROTATE_RIGHT_CARRY, OP_EXT_ROTATE_RIGHT_UNSIGNED, OP_EXT_ROTATE_RIGHT_ARITH}
		|=> !flags_r[FLG_V] && flags_r[FLG_Z] == (result_r == 20'h0_0000))
		else $error("rotate flags wrong");
	AST_SWPB: assert property (state_r == ST_EXEC && op_r == OP_SWPB
		|=> $stable(flags_r) && dst_r[7:0] == $past(dst_r[15:8]))
		else $error("byte swap wrong");

	COV_ADD: cover property (state_r == ST_EXEC && op_r == OP_ADD && wid_r == W_8);
	COV_MPUSH: cover property (state_r == ST_MULTI && op_r == OP_MPUSH && cnt_r == 4'h0);
	COV_LENERR: cover property (go && go_wid == W_NONE);

endmodule : extended_instruction_alu

/* File: testbench/bus_master_model.sv */
`timescale 1ns/1ps
module bus_master_model
	import ext_alu_pkg::*;
(
	// Clock and answer
	input wire logic clk_in,
	input wire logic ack_in,
	input wire logic [31:0] dat_in,
	// Request
	output logic cyc_out,
	output logic stb_out,
	output logic we_out,
	output logic [ADR_W-1:0] adr_out,
	output logic [3:0] sel_out,
	output logic [31:0] dat_out
);
	initial
		{cyc_out, stb_out, we_out, adr_out, sel_out, dat_out} = '0;

	////////////////////////////////////////////////////////////////////////////
	// The request stands until ack is sampled high or 64 clocks pass; a missing answer ends the test as a failure.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int i;
		@(posedge clk_in);
		{cyc_out, stb_out, we_out, sel_out} <= {2'b11, w, 4'hf};
		adr_out <= a;
		dat_out <= d;
		for (i = 0; i < 64; i++)
		begin
			@(posedge clk_in);
			if (ack_in === 1'b1)
				break;
		end
		q = dat_in;
		{cyc_out, stb_out, we_out} <= 3'b000;
		if (i == 64)
		begin
			extended_instruction_alu_test.fails++;
			extended_instruction_alu_test.conclude();
		end
	endtask : xfer
endmodule : bus_master_model

/* File: testbench/extended_instruction_alu_test.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module extended_instruction_alu_test;
	import ext_alu_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic cyc, stb, we, ack, busy;
	logic [ADR_W-1:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, q;
	int fails = 0;
	int checks = 0;
	always #4 clk = ~clk;

	extended_instruction_alu #(.STACK_DEPTH(8)) uut (.ref_clk_in(clk), .resetn_in(resetn),
		.wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
		.wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .busy_out(busy));
	bus_master_model bus (.clk_in(clk), .ack_in(ack), .dat_in(rdat), .cyc_out(cyc),
		.stb_out(stb), .we_out(we), .adr_out(adr), .sel_out(sel), .dat_out(wdat));

	////////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("Checks %0d, errors %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus.xfer(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		bus.xfer(1'b0, a, 32'h0, q);
		`CHK(nm, e, q)
	endtask : rd

	// Register 4 is the fixed index, so a one-register pop lands in it.
	task automatic run(input op_e op, input logic [3:0] cnt, input logic bw, al,
		input logic [19:0] s, dv, input logic [3:0] f, input logic [19:0] ed,
		input logic [3:0] ef);
		int i;
		wr(ADR_SRC, {12'h0, s});
		wr(ADR_DST, {12'h0, dv});
		wr(ADR_FLAGS, {28'h0, f});
		wr(ADR_CTRL, {1'b1, 11'h0, 4'h4, cnt, 2'b00, al, bw, 3'h0, op});
		for (i = 0; i < 40; i++)
		begin
			bus.xfer(1'b0, ADR_STATUS, 32'h0, q);
			if (q[STS_BUSY] === 1'b0)
				break;
		end
		if (i == 40)
		begin
			fails++;
			conclude();
		end
		rd(ADR_DST, {12'h0, ed}, "dst");
		rd(ADR_FLAGS, {28'h0, ef}, "flags");
	endtask : run

	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		run(OP_MOVE, 0, 1, 0, 'h12345, 'h0, 'hA, 'h12345, 'hA);
		run(OP_ADD, 0, 0, 1, 'h8000, 'h8000, 0, 'h0, 'hB);
		run(OP_ADDC, 0, 1, 1, 'hFF, 'h01, 1, 'h01, 'h1);
		run(OP_SUB, 0, 1, 0, 'h1, 'h0, 0, 'hFFFFF, 'h4);
		run(OP_CMP, 0, 0, 1, 'h5, 'h5, 0, 'h5, 'h3);
		run(OP_SUBC, 0, 1, 1, 'h01, 'h10, 0, 'h0E, 'h1);
		run(OP_DADD, 0, 0, 1, 'h0199, 'h0001, 1, 'h0201, 'h0);
		run(OP_BIT, 0, 1, 1, 'h80, 'h80, 'h8, 'h80, 'h5);
		run(OP_BIC, 0, 1, 0, 'h0000F, 'hFFFFF, 'hF, 'hFFFF0, 'hF);
		run(OP_BIS, 0, 0, 1, 'h00F0, 'h000F, 0, 'h00FF, 0);
		run(OP_XOR, 0, 0, 1, 'hFFFF, 'hFFFF, 0, 'h0, 'hA);
		run(OP_AND, 0, 1, 0, 'hF0000, 'h80001, 'hF, 'h80000, 'h5);
		run(OP_EXT_ROTATE_RIGHT_CARRY, 0, 1, 1, 0, 'h01, 1, 'h80, 'h5);
		run(OP_EXT_ROTATE_RIGHT_ARITH, 0, 0, 1, 0, 'h8002, 'h8, 'hC001, 'h4);
		run(OP_EXT_ROTATE_RIGHT_UNSIGNED, 0, 1, 0, 0, 'h80001, 0, 'h40000, 'h1);
		run(OP_SWPB, 0, 0, 1, 0, 'h1234, 'h6, 'h3412, 'h6);
		run(OP_SXT, 0, 0, 0, 0, 'h00080, 0, 'hFFF80, 'h5);
		run(OP_MULTI_ROTATE_RIGHT_UNSIGNED, 3, 0, 1, 0, 'h0018, 'h8, 'h0001, 'h1);
		run(OP_MULTI_SHIFT_LEFT_ARITH, 0, 0, 0, 0, 'h40000, 0, 'h80000, 'hC);
		run(OP_ADD, 0, 0, 0, 1, 'h5, 0, 'h5, 0);
		rd(ADR_STATUS, 32'h2, "status");
		wr(ADR_SP, 32'h8);
		run(OP_PUSH, 0, 1, 0, 'h12345, 0, 'h3, 0, 'h3);
		rd(ADR_SP, 32'h7, "sp");
		run(OP_MPOP, 0, 0, 0, 0, 0, 'h3, 0, 'h3);
		rd(8'h50, 32'h12345, "reg4");
		rd(ADR_SP, 32'h8, "sp");
		run(OP_MPUSH, 1, 0, 1, 0, 0, 'h6, 0, 'h6);
		rd(ADR_SP, 32'h6, "sp");
		run(OP_MPOP, 1, 0, 0, 0, 0, 'h6, 0, 'h6);
		rd(8'h50, 32'h2345, "reg4");
		rd(8'h4c, 32'h0, "reg3");
		rd(ADR_SP, 32'h8, "sp");
		run(OP_FAR_CALL, 0, 0, 0, 0, 'h54321, 'h9, 'h54321, 'h9);
		rd(ADR_PC, 32'h54321, "pc");
		wr(ADR_ADDR_LO, 32'h2345);
		wr(ADR_ADDR_HI, 32'h1);
		wr(ADR_CTRL, {1'b1, 11'h0, 4'h4, 4'h0, 4'b0100, 3'h0, OP_FAR_CALL});
		rd(ADR_OPADDR, 32'h12345, "opaddr");
		rd(ADR_PC, 32'h12345, "pc");
		rd(ADR_SP, 32'h6, "sp");
		rd(ADR_FLAGS, 32'h9, "flags");
		conclude();
	end
endmodule : extended_instruction_alu_test
